// [hw/uasc_link_if.sv]
// Purpose: Link between register core and the two serial engines
// Assumes: Single clock domain
// Notes: Engine pulses last one clock
`timescale 1ns/1ns
interface uasc_link_if;
  logic nine_bit, rx_en, rx_line, rx_busy, frame_vld, fe, nf, valid_start;
  logic [8:0] rx_data;
  logic [8:0] tx_data;
  logic tx_req, brk_req, brk_long, ack_data, ack_brk, tx_busy, tx_line;
  modport ctl(output nine_bit, rx_en, rx_line, tx_data, tx_req, brk_req,
    brk_long, input rx_busy, frame_vld, fe, nf, valid_start, rx_data,
    ack_data, ack_brk, tx_busy, tx_line);
  modport rx(input nine_bit, rx_en, rx_line,
    output rx_busy, frame_vld, fe, nf, valid_start, rx_data);
  modport tx(input nine_bit, tx_data, tx_req, brk_req, brk_long,
    output ack_data, ack_brk, tx_busy, tx_line);
endinterface : uasc_link_if

// [hw/uasc_pkg.sv]
// Purpose: Shared constants and register layouts of the serial status block
// Assumes: Byte wide registers on a plain strobe port
// Notes: Bit times are counted in baud periods of the bit clock
package uasc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int CPB_DEF = CLK_HZ / BAUD_HZ;
  localparam int CPB_MIN = 8;
  localparam int CPB_MAX = 65535;
  localparam logic [2:0] ADDR_STAT = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_AUX = 3'h2;
  localparam logic [2:0] ADDR_C3 = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;
  localparam logic [7:0] STAT_RST = 8'hc0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] C3_RST = 8'h00;
  localparam logic [7:0] RX_FLAG_MASK = 8'h3f;
  localparam logic [7:0] TX_FLAG_MASK = 8'hc0;
  localparam logic [4:0] FRAME_BITS = 5'h0a;
  localparam logic [4:0] BRK_TX_SHORT = 5'h0a;
  localparam logic [4:0] BRK_TX_LONG = 5'h0d;
  localparam logic [4:0] BRK_RX_SHORT = 5'h0a;
  localparam logic [4:0] BRK_RX_LONG = 5'h0b;
  typedef struct packed {
    logic tdre; logic tc; logic rx_full_flag; logic idle;
    logic overrun; logic noise_flag; logic framing_error_flag;
    logic parity_error_flag;
  } uasc_stat_t;
  typedef struct packed {
    logic loop_select; logic rx_source_select; logic nine_bit;
    logic parity_en; logic tx_en; logic rx_en; logic rx_wakeup_standby;
    logic send_break;
  } uasc_mode_t;
  typedef struct packed {
    logic break_detected_flag; logic rx_edge_flag; logic rsvd;
    logic rx_invert; logic wake_idle_detect; logic long_break_tx;
    logic break_detect_enable; logic rx_active_flag;
  } uasc_aux_t;
  typedef struct packed {
    logic rx_ninth_bit; logic tx_ninth_bit; logic single_wire_direction;
    logic tx_invert; logic overrun_irq_enable; logic noise_irq_enable;
    logic framing_irq_enable; logic parity_irq_enable;
  } uasc_c3_t;
endpackage : uasc_pkg

// [hw/uasc_rx.sv]
// Purpose: Receive framing engine, mid-bit sampling
// Assumes: Line already synchronised and polarity corrected
// Notes: Holds after a low stop bit so a break yields one frame
`timescale 1ns/1ns
module uasc_rx #(parameter int CPB = 16) (
  input wire logic clk,
  input wire logic srst,
  uasc_link_if.rx lk
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP,
    RX_HOLD} uasc_rx_st_t;
  localparam logic [15:0] HALF = 16'(CPB / 2);
  localparam logic [15:0] LAST = 16'(CPB - 1);
  localparam logic [15:0] PRE = 16'(CPB - 2);
  uasc_rx_st_t st_r;
  logic [15:0] cnt_r;
  logic [3:0] idx_r;
  logic [8:0] sh_r;
  logic nf_r, prev_r;
  wire logic at_last = cnt_r == LAST;
  wire logic [3:0] last_idx = lk.nine_bit ? 4'h8 : 4'h7;
  assign lk.rx_busy = st_r != RX_IDLE;
  always_ff @(posedge clk)
  begin
    lk.frame_vld <= 1'b0;
    lk.valid_start <= 1'b0;
    if (srst)
    begin
      st_r <= RX_IDLE;
      cnt_r <= 16'h0000;
      idx_r <= 4'h0;
      sh_r <= 9'h000;
      nf_r <= 1'b0;
      prev_r <= 1'b1;
      lk.rx_data <= 9'h000;
      lk.fe <= 1'b0;
      lk.nf <= 1'b0;
    end
    else
    begin
      cnt_r <= (st_r == RX_IDLE || at_last) ? 16'h0000 : cnt_r + 16'h0001;
      if (cnt_r == PRE)
        prev_r <= lk.rx_line;
      case (st_r)
        RX_IDLE:
          if (lk.rx_en && !lk.rx_line)
          begin
            st_r <= RX_START;
            nf_r <= 1'b0;
          end
        RX_START:
          if (cnt_r == HALF)
          begin
            cnt_r <= 16'h0000;
            idx_r <= 4'h0;
            st_r <= lk.rx_line ? RX_IDLE : RX_BITS;
            lk.valid_start <= !lk.rx_line;
          end
        RX_BITS:
          if (at_last)
          begin
            sh_r <= {lk.rx_line, sh_r[8:1]};
            nf_r <= nf_r | (prev_r != lk.rx_line);
            idx_r <= idx_r + 4'h1;
            if (idx_r == last_idx)
              st_r <= RX_STOP;
          end
        RX_STOP:
          if (at_last)
          begin
            lk.frame_vld <= 1'b1;
            lk.rx_data <= lk.nine_bit ? sh_r : {1'b0, sh_r[8:1]};
            lk.fe <= !lk.rx_line;
            lk.nf <= nf_r | (prev_r != lk.rx_line);
            st_r <= lk.rx_line ? RX_IDLE : RX_HOLD;
          end
        RX_HOLD:
          if (lk.rx_line)
            st_r <= RX_IDLE;
        default:
          st_r <= RX_IDLE;
      endcase
    end
  end
endmodule : uasc_rx

// [hw/uasc_top.sv]
// Purpose: Status, control and data port of an async serial transceiver
// Assumes: Plain strobe register port, one clock, pins from outside
// Notes: Rx pin and tx pin input pass a three stage synchroniser
// Function
// - Break flag sets on break with detection enabled; write one clears
// - Edge flag sets on falling rx edge, rising if inverted; w1c
// - Receive inversion applies to everything the receiver sees
// - Waking idle in standby sets idle flag only if wake-idle bit set
// - Sent break is 10 or 13 bit times, one more in nine-bit mode
// - Break detected after 10 low bits, or 11 when enabled, plus nine
// - Break detection enabled blocks framing error and rx-full flags
// - Rx-active sets on valid start bit, clears on idle line
// - Held tx ninth bit leaves with the data byte after data write
// - Single-wire mode: direction bit turns tx pin input or output
// - Transmit inversion applies to every transmitted level
// - Overrun flag with its enable raises the error request
// - Noise flag with its enable raises the error request
// - Framing flag with its enable raises the error request
// - Parity flag with its enable raises the error request
// - Data address reads rx buffer, writes separate tx buffer
// - Nine-bit select chooses 11-bit frames instead of 10-bit
// - Rx-full clears by status read with flag set, then data read
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module uasc_top #(parameter int CPB = uasc_pkg::CPB_DEF) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic err_irq
);
  generate
    if (CPB < uasc_pkg::CPB_MIN || CPB > uasc_pkg::CPB_MAX)
    begin : g_bad_cpb
      $error("CPB out of range");
    end
  endgenerate

  localparam logic [15:0] BIT_LAST = 16'(CPB - 1);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] want,
    input logic strobe);
    hit = strobe && (a == want);
  endfunction : hit

  uasc_link_if lnk();

  uasc_rx #(.CPB(CPB)) u_rx (
    .clk(clk),
    .srst(srst),
    .lk(lnk)
  );

  uasc_tx #(.CPB(CPB)) u_tx (
    .clk(clk),
    .srst(srst),
    .lk(lnk)
  );

  uasc_pkg::uasc_stat_t stat_r, stat_nxt;
  uasc_pkg::uasc_mode_t mode_r;
  uasc_pkg::uasc_aux_t aux_r;
  uasc_pkg::uasc_c3_t c3_r;
  logic [7:0] rx_buf_r, tx_buf_r, arm_r, rdata_r;
  logic [2:0] rx_s_r, tp_s_r;
  logic rx_pin_r, tp_pin_r, raw_d_r;
  logic txd_out_r, txd_oe_r, err_irq_r;
  logic brk_pend_r, idle_arm_r, tx_idle_d_r, raf_r;
  logic [15:0] lo_clk_r, hi_clk_r;
  logic [4:0] lo_bits_r, hi_bits_r;
  logic brk_done_r, hi_arm_r;

  wire logic wr_mode = hit(addr, uasc_pkg::ADDR_MODE, wr);
  wire logic wr_aux = hit(addr, uasc_pkg::ADDR_AUX, wr);
  wire logic wr_c3 = hit(addr, uasc_pkg::ADDR_C3, wr);
  wire logic wr_data = hit(addr, uasc_pkg::ADDR_DATA, wr);
  wire logic rd_stat = hit(addr, uasc_pkg::ADDR_STAT, rd);
  wire logic rd_data = hit(addr, uasc_pkg::ADDR_DATA, rd);

  // Line selection and polarity
  wire logic single_wire = mode_r.loop_select & mode_r.rx_source_select;
  wire logic tx_pin_val = lnk.tx_line ^ c3_r.tx_invert;
  wire logic raw_line = !mode_r.loop_select ? rx_pin_r :
    (mode_r.rx_source_select ? tp_pin_r : txd_out_r);
  wire logic rx_line = raw_line ^ aux_r.rx_invert;
  wire logic act_edge = aux_r.rx_invert ? (!raw_d_r && raw_line) :
    (raw_d_r && !raw_line);

  assign lnk.rx_line = rx_line;
  assign lnk.rx_en = mode_r.rx_en;
  assign lnk.nine_bit = mode_r.nine_bit;
  assign lnk.tx_data = {c3_r.tx_ninth_bit, tx_buf_r};
  assign lnk.tx_req = !stat_r.tdre && mode_r.tx_en;
  assign lnk.brk_req = (brk_pend_r | mode_r.send_break) & mode_r.tx_en;
  assign lnk.brk_long = aux_r.long_break_tx;

  // Break length counting on the corrected line
  wire logic lo_bit_end = lo_clk_r == BIT_LAST;
  wire logic [4:0] brk_thr = (aux_r.break_detect_enable ?
    uasc_pkg::BRK_RX_LONG : uasc_pkg::BRK_RX_SHORT) +
    {4'h0, mode_r.nine_bit};
  wire logic brk_hit = !rx_line && mode_r.rx_en && lo_bit_end &&
    !brk_done_r && (lo_bits_r + 5'h01 == brk_thr);

  // Idle line after a frame
  wire logic hi_bit_end = hi_clk_r == BIT_LAST;
  wire logic [4:0] idle_thr = uasc_pkg::FRAME_BITS +
    {4'h0, mode_r.nine_bit};
  wire logic idle_hit = hi_arm_r && rx_line && !lnk.rx_busy &&
    hi_bit_end && (hi_bits_r + 5'h01 == idle_thr);

  // Frame acceptance
  wire logic frame_ok = lnk.frame_vld && !aux_r.break_detect_enable &&
    !mode_r.rx_wakeup_standby;
  wire logic rx_full_flag_set = frame_ok && !stat_r.rx_full_flag;
  wire logic or_set = frame_ok && stat_r.rx_full_flag;
  wire logic par_bad = mode_r.parity_en && (mode_r.nine_bit ?
    ^lnk.rx_data : ^lnk.rx_data[7:0]);
  wire logic idle_set = idle_hit && (mode_r.rx_wakeup_standby ?
    aux_r.wake_idle_detect : idle_arm_r);
  wire logic tx_idle = stat_r.tdre && !lnk.tx_busy && !lnk.brk_req;

  wire logic [7:0] flag_set = {lnk.ack_data, tx_idle && !tx_idle_d_r,
    rx_full_flag_set, idle_set, or_set, rx_full_flag_set && lnk.nf, rx_full_flag_set && lnk.fe,
    rx_full_flag_set && par_bad};
  wire logic [7:0] clr_mask = (rd_data ? uasc_pkg::RX_FLAG_MASK : 8'h00) |
    (wr_data ? uasc_pkg::TX_FLAG_MASK : 8'h00);
  wire logic [7:0] flag_clr = arm_r & clr_mask;
  // Set wins so an event in the clearing cycle is kept
  assign stat_nxt = (stat_r & ~flag_clr) | flag_set;

  wire logic [3:0] err_vec = {c3_r.overrun_irq_enable & stat_r.overrun,
    c3_r.noise_irq_enable & stat_r.noise_flag,
    c3_r.framing_irq_enable & stat_r.framing_error_flag,
    c3_r.parity_irq_enable & stat_r.parity_error_flag};

  wire logic [7:0] rd_mux =
    (addr == uasc_pkg::ADDR_STAT) ? stat_r :
    (addr == uasc_pkg::ADDR_MODE) ? mode_r :
    (addr == uasc_pkg::ADDR_AUX) ? aux_r :
    (addr == uasc_pkg::ADDR_C3) ? c3_r :
    (addr == uasc_pkg::ADDR_DATA) ? rx_buf_r : 8'h00;

  // Three stage synchronisers; change taken when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_s_r <= 3'h7;
      tp_s_r <= 3'h7;
      rx_pin_r <= 1'b1;
      tp_pin_r <= 1'b1;
      raw_d_r <= 1'b1;
    end
    else
    begin
      rx_s_r <= {rx_s_r[1:0], rxd};
      tp_s_r <= {tp_s_r[1:0], txd_in};
      if (rx_s_r[1] == rx_s_r[2])
        rx_pin_r <= rx_s_r[2];
      if (tp_s_r[1] == tp_s_r[2])
        tp_pin_r <= tp_s_r[2];
      raw_d_r <= raw_line;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || rx_line || !mode_r.rx_en)
    begin
      lo_clk_r <= 16'h0000;
      lo_bits_r <= 5'h00;
      brk_done_r <= 1'b0;
    end
    else
    begin
      lo_clk_r <= lo_bit_end ? 16'h0000 : lo_clk_r + 16'h0001;
      if (lo_bit_end)
        lo_bits_r <= lo_bits_r + 5'h01;
      if (brk_hit)
        brk_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || !rx_line || lnk.rx_busy)
    begin
      hi_clk_r <= 16'h0000;
      hi_bits_r <= 5'h00;
    end
    else
    begin
      hi_clk_r <= hi_bit_end ? 16'h0000 : hi_clk_r + 16'h0001;
      if (hi_bit_end)
        hi_bits_r <= hi_bits_r + 5'h01;
    end
  end

  // Idle is reported once per burst of activity
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hi_arm_r <= 1'b0;
      raf_r <= 1'b0;
      idle_arm_r <= 1'b0;
    end
    else
    begin
      hi_arm_r <= lnk.frame_vld | (hi_arm_r & !idle_hit);
      raf_r <= lnk.valid_start | (raf_r & !idle_hit);
      idle_arm_r <= rx_full_flag_set | (idle_arm_r & !idle_set);
    end
  end

  // Status and clear-sequence arming
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stat_r <= uasc_pkg::STAT_RST;
      arm_r <= 8'h00;
      tx_idle_d_r <= 1'b1;
    end
    else
    begin
      stat_r <= stat_nxt;
      arm_r <= rd_stat ? stat_r : (arm_r & ~clr_mask);
      tx_idle_d_r <= tx_idle;
    end
  end

  // Receive buffer; ninth bit lands beside it in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      rx_buf_r <= 8'h00;
    else if (rx_full_flag_set)
      rx_buf_r <= lnk.rx_data[7:0];
  end

  // Tx buffer is write-only and separate from the rx buffer
  always_ff @(posedge clk)
  begin
    if (srst)
      tx_buf_r <= 8'h00;
    else if (wr_data)
      tx_buf_r <= wdata;
  end

  // Sbk written 0 to 1 queues one break; holding it queues more
  always_ff @(posedge clk)
  begin
    if (srst)
      brk_pend_r <= 1'b0;
    else if (wr_mode && wdata[0] && !mode_r.send_break)
      brk_pend_r <= 1'b1;
    else if (lnk.ack_brk)
      brk_pend_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mode_r <= uasc_pkg::MODE_RST;
    else if (wr_mode)
      mode_r <= wdata;
    else if (idle_hit)
      mode_r.rx_wakeup_standby <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      aux_r <= uasc_pkg::AUX_RST;
    else
    begin
      aux_r.break_detected_flag <= (brk_hit &&
        aux_r.break_detect_enable) || (aux_r.break_detected_flag &&
        !(wr_aux && wdata[7]));
      aux_r.rx_edge_flag <= act_edge || (aux_r.rx_edge_flag &&
        !(wr_aux && wdata[6]));
      aux_r.rsvd <= 1'b0;
      aux_r.rx_active_flag <= raf_r;
      if (wr_aux)
        aux_r[4:1] <= wdata[4:1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      c3_r <= uasc_pkg::C3_RST;
    else
    begin
      if (wr_c3)
        c3_r[6:0] <= wdata[6:0];
      if (rx_full_flag_set)
        c3_r.rx_ninth_bit <= lnk.rx_data[8] & mode_r.nine_bit;
    end
  end

  // Pins, read data and error request
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txd_out_r <= 1'b1;
      txd_oe_r <= 1'b1;
      rdata_r <= 8'h00;
      err_irq_r <= 1'b0;
    end
    else
    begin
      txd_out_r <= tx_pin_val;
      txd_oe_r <= single_wire ? c3_r.single_wire_direction : 1'b1;
      rdata_r <= rd ? rd_mux : 8'h00;
      err_irq_r <= |err_vec;
    end
  end

  assign rdata = rdata_r;
  assign txd_out = txd_out_r;
  assign txd_oe = txd_oe_r;
  assign err_irq = err_irq_r;
endmodule : uasc_top

// [hw/uasc_tx.sv]
// Purpose: Transmit shifter for data frames and break characters
// Assumes: Line polarity applied by the caller
// Notes: Data takes precedence over a queued break
`timescale 1ns/1ns
module uasc_tx #(parameter int CPB = 16) (
  input wire logic clk,
  input wire logic srst,
  uasc_link_if.tx lk
);
  typedef enum logic {TX_IDLE, TX_SEND} uasc_tx_st_t;
  localparam logic [15:0] LAST = 16'(CPB - 1);
  uasc_tx_st_t st_r;
  logic [11:0] sh_r;
  logic [4:0] left_r;
  logic [15:0] cnt_r;
  wire logic [4:0] brk_len = (lk.brk_long ? uasc_pkg::BRK_TX_LONG :
    uasc_pkg::BRK_TX_SHORT) + {4'h0, lk.nine_bit};
  wire logic [4:0] frm_len = uasc_pkg::FRAME_BITS + {4'h0, lk.nine_bit};
  assign lk.tx_busy = st_r == TX_SEND;
  assign lk.tx_line = (st_r == TX_SEND) ? sh_r[0] : 1'b1;
  always_ff @(posedge clk)
  begin
    lk.ack_data <= 1'b0;
    lk.ack_brk <= 1'b0;
    if (srst)
    begin
      st_r <= TX_IDLE;
      sh_r <= 12'hfff;
      left_r <= 5'h00;
      cnt_r <= 16'h0000;
    end
    else if (st_r == TX_IDLE)
    begin
      cnt_r <= 16'h0000;
      if (lk.tx_req)
      begin
        sh_r <= lk.nine_bit ? {2'b11, lk.tx_data, 1'b0} :
          {3'b111, lk.tx_data[7:0], 1'b0};
        left_r <= frm_len - 5'h01;
        lk.ack_data <= 1'b1;
        st_r <= TX_SEND;
      end
      else if (lk.brk_req)
      begin
        sh_r <= 12'h000;
        left_r <= brk_len - 5'h01;
        lk.ack_brk <= 1'b1;
        st_r <= TX_SEND;
      end
    end
    else if (cnt_r == LAST)
    begin
      cnt_r <= 16'h0000;
      sh_r <= {1'b0, sh_r[11:1]};
      left_r <= left_r - 5'h01;
      if (left_r == 5'h00)
        st_r <= TX_IDLE;
    end
    else
      cnt_r <= cnt_r + 16'h0001;
  end
endmodule : uasc_tx

// [testbench/uasc_node.sv]
// Purpose: Remote serial node driving the receive pin
// Assumes: Same bit period as the block
// Notes: Line rests at the idle level between frames
`timescale 1ns/1ns
module uasc_node #(parameter int CPB = 16) (
  input wire logic clk,
  output logic line
);
  logic idle_lvl = 1'b1;
  initial line = 1'b1;
  task automatic set_idle(input logic lvl);
    idle_lvl = lvl;
    line <= lvl;
  endtask : set_idle
  // Bit value 1 is the idle level, lsb first
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      line <= bits[i] ~^ idle_lvl;
      repeat (CPB) @(posedge clk);
    end
    line <= idle_lvl;
  endtask : send
endmodule : uasc_node

// [testbench/uasc_top_checker.sv]
// Purpose: Port assertions for the serial status block
// Assumes: Register map of the package
// Notes: Shadows follow bus writes only
`timescale 1ns/1ns
module uasc_top_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic err_irq
);
  logic [7:0] mode_r;
  logic [7:0] aux_r;
  logic [7:0] c3_r;
  wire logic exp_oe = !(mode_r[7] && mode_r[6]) || c3_r[5];
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_r <= 8'h00;
      aux_r <= 8'h00;
      c3_r <= 8'h00;
    end
    else if (wr)
    begin
      if (addr == uasc_pkg::ADDR_MODE)
        mode_r <= wdata;
      if (addr == uasc_pkg::ADDR_AUX)
        aux_r <= wdata;
      if (addr == uasc_pkg::ADDR_C3)
        c3_r <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rst;
    $fell(srst) |-> txd_out && txd_oe && !err_irq && rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pins wrong after reset");
  property p_unmapped;
    rd && addr > 3'h4 |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_aux_rb;
    rd && addr == uasc_pkg::ADDR_AUX |=> rdata[5:1] == {1'b0, aux_r[4:1]};
  endproperty
  a_aux_rb: assert property (p_aux_rb)
    else $error("aux control readback wrong");
  property p_c3_rb;
    rd && addr == uasc_pkg::ADDR_C3 |=> rdata[6:0] == c3_r[6:0];
  endproperty
  a_c3_rb: assert property (p_c3_rb)
    else $error("control three readback wrong");
  property p_irq_off;
    c3_r[3:0] == 4'h0 && $past(c3_r[3:0]) == 4'h0 |-> !err_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("error request with all enables off");
  property p_irq_rose;
    $rose(err_irq) |-> $past(c3_r[3:0]) != 4'h0;
  endproperty
  a_irq_rose: assert property (p_irq_rose)
    else $error("error request rose without enable");
  property p_oe;
    exp_oe == $past(exp_oe) |-> txd_oe == exp_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("tx pin direction wrong");
endmodule : uasc_top_checker
bind uasc_top uasc_top_checker u_chk (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd_out(txd_out),
  .txd_oe(txd_oe), .err_irq(err_irq));

// [testbench/uasc_top_test.sv]
// Purpose: Self-checking bench for the serial status block
// Assumes: Short bit period of 16 clocks
// Notes: Tx pin wire pulled high when nobody drives it
`timescale 1ns/1ns
module uasc_top_test;
  localparam int CPB = 16;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd_out;
  logic txd_oe;
  logic err_irq;
  wire logic txd_in = txd_oe ? txd_out : 1'b1;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] d;
  logic [11:0] v;
  int b;
  initial forever #4 clk = ~clk;
  uasc_node #(.CPB(CPB)) node (.clk(clk), .line(rxd));
  uasc_top #(.CPB(CPB)) dut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
    .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe), .err_irq(err_irq));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wreg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask : rreg
  // Samples n bits after the start bit, mid bit
  task automatic cap(input int n, input logic inv, output logic [11:0] q);
    int k;
    q = 12'h000;
    k = 0;
    while (txd_out !== inv && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    wt(CPB / 2);
    for (int i = 0; i < n; i++)
    begin
      wt(CPB);
      q[i] = txd_out ^ inv;
    end
  endtask : cap
  task automatic blen(output int n);
    int k;
    n = 0;
    k = 0;
    while (txd_out !== 1'b0 && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    while (txd_out === 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    n = (n + CPB / 2) / CPB;
  endtask : blen
  task automatic t_regs;
    rreg(uasc_pkg::ADDR_STAT, d);
    chk(d, uasc_pkg::STAT_RST);
    rreg(uasc_pkg::ADDR_AUX, d);
    chk(d, uasc_pkg::AUX_RST);
    rreg(uasc_pkg::ADDR_C3, d);
    chk(d, uasc_pkg::C3_RST);
    wreg(3'h5, 8'hff);
    rreg(3'h5, d);
    chk(d, 8'h00);
  endtask : t_regs
  task automatic t_tx;
    for (int i = 0; i < 4; i++)
    begin
      wreg(uasc_pkg::ADDR_C3, {3'h2, i[0], 4'h0});
      wreg(uasc_pkg::ADDR_MODE, {2'b00, i[1], 5'h08});
      rreg(uasc_pkg::ADDR_STAT, d);
      fork
        wreg(uasc_pkg::ADDR_DATA, 8'h96);
        cap(9 + i[1], i[0], v);
      join
      chk(v, i[1] ? 12'h396 : 12'h196);
      wt(2 * CPB);
    end
  endtask : t_tx
  task automatic t_brk;
    wreg(uasc_pkg::ADDR_C3, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wreg(uasc_pkg::ADDR_AUX, {5'h00, i[0], 2'b00});
      fork
        begin
          wreg(uasc_pkg::ADDR_MODE, {2'b00, i[1], 5'h09});
          wreg(uasc_pkg::ADDR_MODE, {2'b00, i[1], 5'h08});
        end
        blen(b);
      join
      chk(12'(b), 12'(10 + 3 * i[0] + i[1]));
      wt(2 * CPB);
    end
  endtask : t_brk
  task automatic t_rx;
    for (int i = 0; i < 2; i++)
    begin
      wreg(uasc_pkg::ADDR_MODE, 8'h00);
      node.set_idle(~i[0]);
      wt(8);
      wreg(uasc_pkg::ADDR_AUX, {3'h6, i[0], 4'h0});
      wreg(uasc_pkg::ADDR_MODE, 8'h04);
      fork
        node.send(12'h34a, 10);
        begin
          wt(4 * CPB);
          rreg(uasc_pkg::ADDR_AUX, d);
          chk(d[0], 1'b1);
        end
      join
      wt(2 * CPB);
      rreg(uasc_pkg::ADDR_STAT, d);
      chk(d[5], 1'b1);
      rreg(uasc_pkg::ADDR_DATA, d);
      chk(d, 8'ha5);
      rreg(uasc_pkg::ADDR_STAT, d);
      chk(d[5], 1'b0);
      rreg(uasc_pkg::ADDR_AUX, d);
      chk(d[6], 1'b1);
      wreg(uasc_pkg::ADDR_AUX, {3'h2, i[0], 4'h0});
      wt(12 * CPB);
      rreg(uasc_pkg::ADDR_AUX, d);
      chk({d[6], d[0]}, 2'b00);
    end
  endtask : t_rx
  task automatic t_lin;
    wreg(uasc_pkg::ADDR_MODE, 8'h00);
    node.set_idle(1'b1);
    wt(8);
    wreg(uasc_pkg::ADDR_AUX, 8'hc2);
    wreg(uasc_pkg::ADDR_MODE, 8'h04);
    node.send(12'h000, 10);
    wt(12 * CPB);
    rreg(uasc_pkg::ADDR_AUX, d);
    chk(d[7], 1'b0);
    node.send(12'h000, 12);
    wt(2 * CPB);
    rreg(uasc_pkg::ADDR_AUX, d);
    chk(d[7], 1'b1);
    rreg(uasc_pkg::ADDR_STAT, d);
    chk({d[5], d[1]}, 2'b00);
    wreg(uasc_pkg::ADDR_AUX, 8'h80);
    rreg(uasc_pkg::ADDR_AUX, d);
    chk(d[7], 1'b0);
  endtask : t_lin
  task automatic t_irq;
    wreg(uasc_pkg::ADDR_C3, 8'h00);
    node.send(12'h1fe, 10);
    wt(4 * CPB);
    node.send(12'h266, 10);
    wt(4 * CPB);
    chk(err_irq, 1'b0);
    rreg(uasc_pkg::ADDR_STAT, d);
    chk(d[3:1], 3'h5);
    wreg(uasc_pkg::ADDR_C3, 8'h08);
    wt(2);
    chk(err_irq, 1'b1);
    wreg(uasc_pkg::ADDR_C3, 8'h02);
    wt(2);
    chk(err_irq, 1'b1);
    wreg(uasc_pkg::ADDR_C3, 8'h05);
    wt(2);
    chk(err_irq, 1'b0);
    rreg(uasc_pkg::ADDR_DATA, d);
    wreg(uasc_pkg::ADDR_C3, 8'h0f);
    wt(2);
    chk(err_irq, 1'b0);
  endtask : t_irq
  task automatic t_sw;
    wreg(uasc_pkg::ADDR_MODE, 8'hc0);
    wt(2);
    chk(txd_oe, 1'b0);
    wreg(uasc_pkg::ADDR_C3, 8'h20);
    wt(2);
    chk(txd_oe, 1'b1);
  endtask : t_sw
  // Standby wake by idle, then a nine-bit frame with odd parity
  task automatic t_wake;
    for (int i = 0; i < 2; i++)
    begin
      wreg(uasc_pkg::ADDR_MODE, 8'h24);
      // Let any idle from earlier traffic fire before standby
      wt(24 * CPB);
      rreg(uasc_pkg::ADDR_STAT, d);
      rreg(uasc_pkg::ADDR_DATA, d);
      wreg(uasc_pkg::ADDR_AUX, {4'h0, i[0], 3'h0});
      wreg(uasc_pkg::ADDR_MODE, 8'h36);
      node.send(12'h6b4, 11);
      wt(14 * CPB);
      rreg(uasc_pkg::ADDR_STAT, d);
      chk(d[5:4], {1'b0, i[0]});
      rreg(uasc_pkg::ADDR_MODE, d);
      chk(d[1], 1'b0);
      node.send(12'h6b4, 11);
      wt(2 * CPB);
      rreg(uasc_pkg::ADDR_C3, d);
      chk(d[7], 1'b1);
      wreg(uasc_pkg::ADDR_C3, 8'h01);
      wt(2);
      chk(err_irq, 1'b1);
      rreg(uasc_pkg::ADDR_STAT, d);
      rreg(uasc_pkg::ADDR_DATA, d);
      chk(d, 8'h5a);
      wt(2);
      chk(err_irq, 1'b0);
    end
  endtask : t_wake
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    wt(4);
    srst <= 1'b0;
    t_regs();
    t_tx();
    t_brk();
    t_rx();
    t_lin();
    t_irq();
    t_sw();
    t_wake();
    test_done();
  end
  initial
  begin
    wt(40000);
    num_errors++;
    test_done();
  end
endmodule : uasc_top_test
